// [pkg/mcc_defs.svh]
// Register offsets, field positions, reset values and timing counts of the
// metering core configuration block.
// Assumes a 40 MHz pclk; included by bare name.
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

`define MCC_CFG_OFFSET 16'he618
`define MCC_SOFTWARE_RESET_BIT_CTRL_OFFSET 16'he61c
`define MCC_CFG_RESET 16'h0010
`define MCC_CFG_WMASK 16'h7ffb

`define MCC_PINSEL_LSB 0
`define MCC_SWAP_BIT 3
`define MCC_HPF_BIT 4
`define MCC_LPF_BIT 5
`define MCC_FAST_BIT 6
`define MCC_SOFTWARE_RESET_BIT_BIT 7
`define MCC_VPA_LSB 8
`define MCC_VPB_LSB 10
`define MCC_VPC_LSB 12
`define MCC_NSEL_BIT 14

`define MCC_CLK_HZ 40000000
`define MCC_SETTLE_SHORT_MS 650
`define MCC_SETTLE_LONG_MS 1300
`define MCC_SOFTWARE_RESET_BIT_CYCLES 16

`endif

// [pkg/mcc_pkg.sv]
// Types shared by the metering core configuration block.
// Assumes the offsets and counts in mcc_defs.svh.
package mcc_pkg;

    typedef enum logic [1:0] {
        MCC_PH_A,
        MCC_PH_B,
        MCC_PH_C
    } mcc_phase_t;

    typedef struct packed {
        logic [1:0] pin_function_select;
        logic swap_channels;
        logic highpass_filter_enable;
        logic lowpass_settling_select;
        logic fast_capture_port_enable;
        mcc_phase_t phase_a_voltage_pairing;
        mcc_phase_t phase_b_voltage_pairing;
        mcc_phase_t phase_c_voltage_pairing;
        logic neutral_rms_source_select;
    } mcc_ctrl_t;

endpackage

// [design/mcc_pairing_decode.sv]
// Decodes one two-bit voltage pairing field into a phase.
// Assumes the field comes straight from the configuration register.
`timescale 1ns/10ps
`default_nettype none

module mcc_pairing_decode (
    // Field and the phase of this current channel.
    input wire logic [1:0] field,
    input wire mcc_pkg::mcc_phase_t own_phase,
    // Selected voltage phase.
    output mcc_pkg::mcc_phase_t voltage_phase
);

    logic [1:0] own_idx;
    logic [2:0] sum;

    // Code 11 falls back to the channel's own phase like code 00.
    // The sum is one bit wider so that phase C plus two does not wrap early.
    always_comb begin
        own_idx = 2'(own_phase);
        sum = (field == 2'h3) ? {1'b0, own_idx} : {1'b0, own_idx} + {1'b0, field};
        if (sum >= 3'h3) begin
            sum = sum - 3'h3;
        end
        voltage_phase = mcc_pkg::mcc_phase_t'(sum[1:0]);
    end

endmodule

`default_nettype wire

// [design/mcc_config_reg.sv]
// Configuration register of the metering core with APB access and the
// decode of its fields into control of the shared pins and datapaths.
// Assumes a 40 MHz pclk, an APB master, and datapath blocks outside.
//
// Operation
// - Pin-function 00 routes sample-ready to pin.
// - Codes 01/10/11 route phase A/B/C zero-crossing.
// - Bit 2 reads zero, resets zero.
// - Bit 3 swaps voltage and current outputs.
// - Bit 4 enables all high-pass filters.
// - Bit 5 selects 650 or 1300 ms settling.
// - Bit 6 selects fast port clock or pulse.
// - Writing bit 7 starts a software reset.
// - Bits 9:8 pair voltage with phase A.
// - Bits 11:10 pair voltage with phase B.
// - Bits 13:12 pair voltage with phase C.
// - Bit 14 selects neutral or summed rms source.
// - Bit 15 reserved, no effect, resets zero.
`timescale 1ns/10ps
`default_nettype none
`include "mcc_defs.svh"

module mcc_config_reg (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sources for the shared output pin.
    input wire logic sample_ready_output,
    input wire logic [2:0] zero_crossing_output,
    output logic shared_pin_out,
    // Sources for the pulse and fast clock pin.
    input wire logic third_pulse_output,
    input wire logic fast_capture_clock,
    output logic pulse_clock_pin_out,
    // Decoded controls for the datapath.
    output mcc_pkg::mcc_ctrl_t ctrl,
    output logic [31:0] settling_cycles,
    // Software reset of the rest of the core.
    output logic soft_reset_active
);

    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [4:0] software_reset_bit_cnt_q;
    logic software_reset_bit_q;
    logic access;
    logic wr_cfg;
    logic hit_cfg;
    logic hit_ctrl;
    logic [15:0] wmerge;
    mcc_pkg::mcc_phase_t pair_phase [3];
    logic [1:0] pair_field [3];

    localparam logic [31:0] SETTLE_SHORT =
        32'(`MCC_SETTLE_SHORT_MS * (`MCC_CLK_HZ / 1000));
    localparam logic [31:0] SETTLE_LONG =
        32'(`MCC_SETTLE_LONG_MS * (`MCC_CLK_HZ / 1000));

    assign access = psel && penable;
    assign hit_cfg = (paddr == `MCC_CFG_OFFSET);
    assign hit_ctrl = (paddr == `MCC_SOFTWARE_RESET_BIT_CTRL_OFFSET);
    assign wr_cfg = access && pwrite && hit_cfg;

    // The slave never waits; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign pslverr = access && !(hit_cfg || hit_ctrl);

    // Byte strobes merge the low two lanes into the stored value.
    always_comb begin
        wmerge = cfg_q;
        if (pstrb[0]) begin
            wmerge[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            wmerge[15:8] = pwdata[15:8];
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        if (software_reset_bit_q && software_reset_bit_cnt_q == 5'h0) begin
            cfg_d = `MCC_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_d = wmerge & `MCC_CFG_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `MCC_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // A written one starts a fixed-length reset pulse to the core; the bit
    // stays readable as one until the pulse ends and defaults return.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            software_reset_bit_q <= 1'b0;
            software_reset_bit_cnt_q <= 5'h0;
        end else if (!software_reset_bit_q && wr_cfg && pstrb[0] && pwdata[`MCC_SOFTWARE_RESET_BIT_BIT]) begin
            software_reset_bit_q <= 1'b1;
            software_reset_bit_cnt_q <= 5'(`MCC_SOFTWARE_RESET_BIT_CYCLES - 1);
        end else if (software_reset_bit_q) begin
            if (software_reset_bit_cnt_q == 5'h0) begin
                software_reset_bit_q <= 1'b0;
            end else begin
                software_reset_bit_cnt_q <= software_reset_bit_cnt_q - 5'h1;
            end
        end
    end

    assign soft_reset_active = software_reset_bit_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `MCC_CFG_OFFSET) begin
                prdata <= {16'h0, cfg_q[15:8], software_reset_bit_q, cfg_q[6:0]};
            end else if (paddr == `MCC_SOFTWARE_RESET_BIT_CTRL_OFFSET) begin
                prdata <= {27'h0, software_reset_bit_cnt_q};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    assign pair_field[0] = cfg_q[`MCC_VPA_LSB +: 2];
    assign pair_field[1] = cfg_q[`MCC_VPB_LSB +: 2];
    assign pair_field[2] = cfg_q[`MCC_VPC_LSB +: 2];

    for (genvar i = 0; i < 3; i++) begin : g_pair
        mcc_pairing_decode u_dec (
            .field(pair_field[i]),
            .own_phase(mcc_pkg::mcc_phase_t'(i)),
            .voltage_phase(pair_phase[i])
        );
    end

    always_comb begin
        ctrl.pin_function_select = cfg_q[`MCC_PINSEL_LSB +: 2];
        ctrl.swap_channels = cfg_q[`MCC_SWAP_BIT];
        ctrl.highpass_filter_enable = cfg_q[`MCC_HPF_BIT];
        ctrl.lowpass_settling_select = cfg_q[`MCC_LPF_BIT];
        ctrl.fast_capture_port_enable = cfg_q[`MCC_FAST_BIT];
        ctrl.phase_a_voltage_pairing = pair_phase[0];
        ctrl.phase_b_voltage_pairing = pair_phase[1];
        ctrl.phase_c_voltage_pairing = pair_phase[2];
        ctrl.neutral_rms_source_select = cfg_q[`MCC_NSEL_BIT];
    end

    assign settling_cycles = cfg_q[`MCC_LPF_BIT] ? SETTLE_LONG : SETTLE_SHORT;

    always_comb begin
        unique case (cfg_q[`MCC_PINSEL_LSB +: 2])
            2'h0: shared_pin_out = sample_ready_output;
            2'h1: shared_pin_out = zero_crossing_output[0];
            2'h2: shared_pin_out = zero_crossing_output[1];
            2'h3: shared_pin_out = zero_crossing_output[2];
        endcase
    end

    assign pulse_clock_pin_out = cfg_q[`MCC_FAST_BIT] ? fast_capture_clock
                                                      : third_pulse_output;

endmodule

`default_nettype wire

// [dv/mcc_config_reg_assertions.sv]
// Checker for the configuration register pins, decode and soft reset.
// Bound to mcc_config_reg; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mcc_config_reg_assertions (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Pins and controls.
    input wire logic sample_ready_output,
    input wire logic [2:0] zero_crossing_output,
    input wire logic shared_pin_out,
    input wire logic third_pulse_output,
    input wire logic fast_capture_clock,
    input wire logic pulse_clock_pin_out,
    input wire mcc_pkg::mcc_ctrl_t ctrl,
    input wire logic [31:0] settling_cycles,
    input wire logic soft_reset_active
);
    logic wr;
    logic [1:0] ps;
    assign wr = psel && penable && pwrite && paddr == 16'he618 && !soft_reset_active;
    assign ps = ctrl.pin_function_select;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pin_a: assert property (
        ps == 2'h0 |-> shared_pin_out == sample_ready_output) else $error("ready mux");
    zero_cross_a: assert property (
        ps != 2'h0 |-> shared_pin_out == zero_crossing_output[ps - 2'h1]) else $error("zx mux");
    hpf_write_a: assert property (
        wr |=> ctrl.highpass_filter_enable == $past(pwdata[4])) else $error("hpf");
    settle_len_a: assert property (
        settling_cycles == (ctrl.lowpass_settling_select ? 32'h3197500 : 32'h18cba80))
        else $error("settle");
    pulse_pin_a: assert property (
        pulse_clock_pin_out == (ctrl.fast_capture_port_enable ? fast_capture_clock
        : third_pulse_output)) else $error("pulse mux");
    software_reset_bit_start_a: assert property (
        wr && pwdata[7] |=> soft_reset_active [*8]) else $error("software_reset_bit start");
    rsv_read_a: assert property (
        psel && !penable && paddr == 16'he618 |=> !prdata[2] && !prdata[15])
        else $error("reserved");
    software_reset_bit_end_a: assert property (
        $fell(soft_reset_active) |-> ctrl.highpass_filter_enable && ps == 2'h0)
        else $error("software_reset_bit end");
    cover property (wr);
    cover property ($fell(soft_reset_active));
    cover property (ps == 2'h3);
endmodule
bind mcc_config_reg mcc_config_reg_assertions u_chk (.*);
`default_nettype wire

// [dv/tb_metering_core_config_register.sv]
// Self-checking bench for the configuration register over APB.
// Drives every port itself; pclk at 40 MHz.
`timescale 1ns/10ps
`default_nettype none
module tb_metering_core_config_register;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, settling_cycles, r, d;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] v;
    logic pready, pslverr, shared_pin_out, pulse_clock_pin_out, soft_reset_active, err;
    logic sample_ready_output = 0, third_pulse_output = 0, fast_capture_clock = 0;
    logic [2:0] zero_crossing_output = 3'h0;
    mcc_pkg::mcc_ctrl_t ctrl;
    int errors = 0, check_count = 0, n;
    mcc_config_reg u_dut (.*);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        {sample_ready_output, zero_crossing_output} <= 4'($urandom);
        {third_pulse_output, fast_capture_clock} <= 2'($urandom);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Codes 01 and 10 step away from the own phase; 00 keeps it and 11 falls back to it.
    function automatic logic [1:0] pr(input logic [1:0] f, input logic [1:0] own);
        return f == 2'h3 ? own : 2'((int'(own) + int'(f)) % 3);
    endfunction
    initial begin
        void'($urandom(56562));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, 16'he618, 0);
        chk(r, 32'h10);
        for (int i = 0; i < 24; i++) begin
            d = ($urandom & 32'hffffc07c) | (i % 4) * 32'h1501;
            apb(1, 16'he618, d);
            apb(0, 16'he618, 0);
            chk(r, {16'h0, d[15:0] & 16'h7ffb});
            chk({ctrl.highpass_filter_enable, ctrl.swap_channels}, d[4:3]);
            chk(settling_cycles, d[5] ? 32'h3197500 : 32'h18cba80);
            chk(ctrl.neutral_rms_source_select, d[14]);
            chk(ctrl.phase_a_voltage_pairing, pr(d[9:8], 2'h0));
            chk(ctrl.phase_b_voltage_pairing, pr(d[11:10], 2'h1));
            chk(ctrl.phase_c_voltage_pairing, pr(d[13:12], 2'h2));
            @(negedge pclk);
            v = {zero_crossing_output, sample_ready_output};
            chk(shared_pin_out, v[d[1:0]]);
            chk(pulse_clock_pin_out, d[6] ? fast_capture_clock : third_pulse_output);
        end
        apb(1, 16'he620, 32'hffff);
        chk(err, 1'b1);
        apb(0, 16'he618, 0);
        chk(r[15:0], d[15:0] & 16'h7ffb);
        apb(1, 16'he618, 32'h4088);
        n = 0;
        repeat (40) begin
            @(posedge pclk);
            n += soft_reset_active;
        end
        chk(n, 16);
        apb(0, 16'he618, 0);
        chk(r, 32'h10);
        finish_test;
    end
    initial begin
        #100us;
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
